/* common/rail_fault_params.svh */
// Register offsets, field positions and reset values of the rail fault bank.
`ifndef RAIL_FAULT_PARAMS_SVH
`define RAIL_FAULT_PARAMS_SVH

`define REG_FAULT_MASK     8'hA3
`define REG_DISCHARGE      8'hAD
`define REG_AUX_LDO        8'hAE
`define REG_RAIL_GOOD      8'hB0

`define RST_FAULT_MASK     8'h37
`define WR_MASK_FAULT      8'h7F
`define RST_DISCHARGE      8'h61
`define RST_AUX_DIS_SEL    2'h1
`define RST_AUX_KEEP_ON    1'h1
`define RST_RAIL_GOOD      8'h00

`define FM_ANALOG5V_BIT    5
`define FM_AUX_LDO_BIT     4
`define FM_TERM_BIT        3
`define FM_LSW_MSB         2
`define FM_LSW_LSB         1
`define FM_THIRD_LDO_BIT   0
`define LSW_MASKED_CODE    2'h3

`define TERM_DIS_BIT       4
`define AUX_DIS_MSB        7
`define AUX_DIS_LSB        6
`define AUX_KEEP_ON_BIT    5
`define AUX_VID_MSB        4
`define AUX_VID_LSB        1
`define AUX_EN_BIT         0

// Arbitrary neutral bus address; the real one is set per product.
`define DEV_ADDR_DEFAULT   7'h2A

`endif

/* common/rail_fault_pkg.sv */
// Types shared by the rail fault register bank.
package rail_fault_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } serial_state_t;

endpackage : rail_fault_pkg

/* src/sync_two_flop.sv */
// Two-flop synchroniser for a group of independent pin levels.
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Only the second stage reads the first; each bit is a separate level.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sync_two_flop

`default_nettype wire

/* src/fault_shutdown_gate.sv */
// Gates rail faults by their masks and latches the shutdown request.
`timescale 1ns/1ps
`default_nettype none

`include "rail_fault_params.svh"

module fault_shutdown_gate
  import rail_fault_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire rail_fault_pkg::reg_byte_t mask_in,
  input  wire logic                  analog5v_fault_in,
  input  wire logic                  aux_ldo_fault_in,
  input  wire logic                  termination_fault_in,
  input  wire logic                  load_switch_fault_in,
  input  wire logic                  third_ldo_fault_in,
  output var  logic                  shutdown_req_out
);

  logic hit_analog5v;
  logic hit_aux_ldo;
  logic hit_term;
  logic hit_lsw;
  logic hit_third;
  logic any_hit;

  assign hit_analog5v = analog5v_fault_in & ~mask_in[`FM_ANALOG5V_BIT];
  assign hit_aux_ldo  = aux_ldo_fault_in & ~mask_in[`FM_AUX_LDO_BIT];
  assign hit_term     = termination_fault_in & ~mask_in[`FM_TERM_BIT];
  // Reserved codes count as unmasked so a bad write never hides a fault.
  assign hit_lsw      = load_switch_fault_in &
                        (mask_in[`FM_LSW_MSB:`FM_LSW_LSB] !=
                         `LSW_MASKED_CODE);
  assign hit_third    = third_ldo_fault_in &
                        ~mask_in[`FM_THIRD_LDO_BIT];
  assign any_hit      = hit_analog5v | hit_aux_ldo | hit_term |
                        hit_lsw | hit_third;

  // Shutdown stays requested until the chip is reset.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      shutdown_req_out <= 1'b0;
    else if (any_hit)
      shutdown_req_out <= 1'b1;
  end

endmodule : fault_shutdown_gate

`default_nettype wire

/* src/pmic_rail_fault_ctrl_regs.sv */
// Rail fault mask, discharge, aux LDO and power-good registers on I2C.
`timescale 1ns/1ps
`default_nettype none

`include "rail_fault_params.svh"

module pmic_rail_fault_ctrl_regs
  import rail_fault_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n_out,
  input  wire logic [3:0] otp_aux_ldo_voltage_code_in,
  input  wire logic       otp_aux_ldo_enable_in,
  input  wire logic       analog5v_fault_in,
  input  wire logic       aux_ldo_fault_in,
  input  wire logic       termination_fault_in,
  input  wire logic       load_switch_fault_in,
  input  wire logic       third_ldo_fault_in,
  input  wire logic       second_ldo_good_in,
  input  wire logic       stepdown_rail_six_good_in,
  input  wire logic       stepdown_rail_five_good_in,
  input  wire logic       stepdown_rail_four_good_in,
  input  wire logic       stepdown_rail_three_good_in,
  input  wire logic       stepdown_rail_two_good_in,
  input  wire logic       stepdown_rail_one_good_in,
  output var  logic       termination_discharge_out,
  output var  logic [1:0] aux_ldo_discharge_sel_out,
  output var  logic       aux_ldo_keep_on_in_emergency_out,
  output var  logic [3:0] aux_ldo_voltage_code_out,
  output var  logic       aux_ldo_enable_out,
  output var  logic       aux_ldo_run_out,
  output var  logic       shutdown_req_out
);

  //////////////////////////////////////////////////////////////////////////

  function automatic logic [3:0] reg_hit(input reg_byte_t addr);
    reg_hit = {addr == `REG_RAIL_GOOD,
               addr == `REG_AUX_LDO,
               addr == `REG_DISCHARGE,
               addr == `REG_FAULT_MASK};
  endfunction : reg_hit

  //////////////////////////////////////////////////////////////////////////

  logic [1:0]    bus_sync;
  logic [4:0]    fault_sync;
  logic [6:0]    good_sync;
  logic          scl_s;
  logic          sda_s;
  logic          scl_prev_q;
  logic          sda_prev_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;

  serial_state_t state_q;
  serial_state_t state_d;
  logic [2:0]    bit_cnt_q;
  logic [2:0]    bit_cnt_d;
  reg_byte_t     shift_q;
  reg_byte_t     shift_d;
  reg_byte_t     tx_q;
  reg_byte_t     tx_d;
  reg_byte_t     ptr_q;
  reg_byte_t     ptr_d;
  logic          drive_q;
  logic          drive_d;
  logic          rw_q;
  logic          rw_d;
  logic          byte_done_q;
  logic          byte_done_d;
  logic          mack_q;
  logic          mack_d;
  logic          wr_stb;

  reg_byte_t     fault_mask_q;
  reg_byte_t     discharge_q;
  reg_byte_t     aux_ldo_q;
  reg_byte_t     rail_good_q;
  reg_byte_t     read_val;
  logic [3:0]    rd_hit;
  logic [3:0]    wr_hit;
  logic          aux_run_q;

  //////////////////////////////////////////////////////////////////////////

  sync_two_flop #(.WIDTH(2)) u_bus_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({~scl_in, ~sda_in}), // Inverted so reset reads idle.
    .sync_out (bus_sync)
  );

  sync_two_flop #(.WIDTH(5)) u_fault_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({analog5v_fault_in, aux_ldo_fault_in, termination_fault_in,
                load_switch_fault_in, third_ldo_fault_in}),
    .sync_out (fault_sync)
  );

  sync_two_flop #(.WIDTH(7)) u_good_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({second_ldo_good_in, stepdown_rail_six_good_in,
                stepdown_rail_five_good_in, stepdown_rail_four_good_in,
                stepdown_rail_three_good_in, stepdown_rail_two_good_in,
                stepdown_rail_one_good_in}),
    .sync_out (good_sync)
  );

  fault_shutdown_gate u_gate (
    .clk_in               (clk_in),
    .rst_in               (rst_in),
    .mask_in              (fault_mask_q),
    .analog5v_fault_in    (fault_sync[4]),
    .aux_ldo_fault_in     (fault_sync[3]),
    .termination_fault_in (fault_sync[2]),
    .load_switch_fault_in (fault_sync[1]),
    .third_ldo_fault_in   (fault_sync[0]),
    .shutdown_req_out     (shutdown_req_out)
  );

  //////////////////////////////////////////////////////////////////////////

  assign scl_s     = ~bus_sync[1];
  assign sda_s     = ~bus_sync[0];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  assign rd_hit    = reg_hit(ptr_q);
  assign wr_hit    = wr_stb ? reg_hit(ptr_q) : 4'h0;
  // Unmapped pointers read as zero so a stray read is harmless.
  assign read_val  = ({8{rd_hit[0]}} & fault_mask_q) |
                     ({8{rd_hit[1]}} & discharge_q) |
                     ({8{rd_hit[2]}} & aux_ldo_q) |
                     ({8{rd_hit[3]}} & rail_good_q);

  // Open drain: the pin is only ever pulled low.
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~drive_q;

  //////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    state_d     = state_q;
    bit_cnt_d   = bit_cnt_q;
    shift_d     = shift_q;
    tx_d        = tx_q;
    ptr_d       = ptr_q;
    drive_d     = drive_q;
    rw_d        = rw_q;
    byte_done_d = byte_done_q;
    mack_d      = mack_q;
    wr_stb      = 1'b0;
    if (stop_det)
    begin
      state_d = ST_IDLE;
      drive_d = 1'b0;
    end
    else if (start_det)
    begin
      state_d     = ST_ADDR;
      bit_cnt_d   = 3'h0;
      byte_done_d = 1'b0;
      drive_d     = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          drive_d = 1'b0;
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_d     = {shift_q[6:0], sda_s};
            bit_cnt_d   = bit_cnt_q + 3'h1;
            byte_done_d = (bit_cnt_q == 3'h7);
          end
          else if (scl_fall && byte_done_q)
          begin
            byte_done_d = 1'b0;
            bit_cnt_d   = 3'h0;
            drive_d     = 1'b1;
            if (state_q == ST_ADDR)
            begin
              if (shift_q[7:1] == DEV_ADDR)
              begin
                rw_d    = shift_q[0];
                state_d = ST_ADDR_ACK;
              end
              else
              begin
                drive_d = 1'b0;
                state_d = ST_IDLE;
              end
            end
            else if (state_q == ST_PTR)
            begin
              ptr_d   = shift_q;
              state_d = ST_PTR_ACK;
            end
            else
            begin
              wr_stb  = 1'b1;
              ptr_d   = ptr_q + 8'h01;
              state_d = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_q)
            begin
              tx_d      = read_val;
              drive_d   = ~read_val[7];
              ptr_d     = ptr_q + 8'h01;
              bit_cnt_d = 3'h0;
              state_d   = ST_RDATA;
            end
            else
            begin
              drive_d = 1'b0;
              state_d = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            drive_d = 1'b0;
            state_d = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == 3'h7)
            begin
              drive_d = 1'b0;
              state_d = ST_RDATA_ACK;
            end
            else
            begin
              bit_cnt_d = bit_cnt_q + 3'h1;
              tx_d      = {tx_q[6:0], 1'b0};
              drive_d   = ~tx_q[6];
            end
          end
        end
        ST_RDATA_ACK:
        begin
          if (scl_rise)
            mack_d = ~sda_s;
          else if (scl_fall)
          begin
            if (mack_q)
            begin
              tx_d      = read_val;
              drive_d   = ~read_val[7];
              ptr_d     = ptr_q + 8'h01;
              bit_cnt_d = 3'h0;
              state_d   = ST_RDATA;
            end
            else
              state_d = ST_IDLE;
          end
        end
        default:
        begin
          drive_d = 1'b0;
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      tx_q        <= 8'h00;
      ptr_q       <= 8'h00;
      drive_q     <= 1'b0;
      rw_q        <= 1'b0;
      byte_done_q <= 1'b0;
      mack_q      <= 1'b0;
      scl_prev_q  <= 1'b1;
      sda_prev_q  <= 1'b1;
    end
    else
    begin
      state_q     <= state_d;
      bit_cnt_q   <= bit_cnt_d;
      shift_q     <= shift_d;
      tx_q        <= tx_d;
      ptr_q       <= ptr_d;
      drive_q     <= drive_d;
      rw_q        <= rw_d;
      byte_done_q <= byte_done_d;
      mack_q      <= mack_d;
      scl_prev_q  <= scl_s;
      sda_prev_q  <= sda_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Bit 7 of the mask register is kept out of the write path.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      fault_mask_q <= `RST_FAULT_MASK;
    else if (wr_hit[0])
      fault_mask_q <= shift_q & `WR_MASK_FAULT;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      discharge_q <= `RST_DISCHARGE;
    else if (wr_hit[1])
      discharge_q <= shift_q;
  end

  // Reset takes the OTP defaults, which are static while reset is held.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      aux_ldo_q <= {`RST_AUX_DIS_SEL, `RST_AUX_KEEP_ON,
                    otp_aux_ldo_voltage_code_in,
                    otp_aux_ldo_enable_in};
    else if (wr_hit[2])
      aux_ldo_q <= shift_q;
  end

  // No write path at all; bit 6 always reads zero.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rail_good_q <= `RST_RAIL_GOOD;
    else
      rail_good_q <= {good_sync[6], 1'b0, good_sync[5:0]};
  end

  // Emergency shutdown keeps the aux LDO only when kept on and enabled.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      aux_run_q <= 1'b0;
    else
      aux_run_q <= aux_ldo_q[`AUX_EN_BIT] &
                   (~shutdown_req_out | aux_ldo_q[`AUX_KEEP_ON_BIT]);
  end

  //////////////////////////////////////////////////////////////////////////

  assign termination_discharge_out        = discharge_q[`TERM_DIS_BIT];
  assign aux_ldo_discharge_sel_out        =
    aux_ldo_q[`AUX_DIS_MSB:`AUX_DIS_LSB];
  assign aux_ldo_keep_on_in_emergency_out = aux_ldo_q[`AUX_KEEP_ON_BIT];
  assign aux_ldo_voltage_code_out         =
    aux_ldo_q[`AUX_VID_MSB:`AUX_VID_LSB];
  assign aux_ldo_enable_out               = aux_ldo_q[`AUX_EN_BIT];
  assign aux_ldo_run_out                  = aux_run_q;

endmodule : pmic_rail_fault_ctrl_regs

`default_nettype wire

/* bench/pmic_rail_fault_ctrl_regs_chk.sv */
// Port-level checks of the rail fault register bank.
`timescale 1ns/1ps
`default_nettype none

module rail_fault_regs_chk (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_oe_n_out,
  input  wire logic [3:0] otp_aux_ldo_voltage_code_in,
  input  wire logic       otp_aux_ldo_enable_in,
  input  wire logic       analog5v_fault_in,
  input  wire logic       aux_ldo_fault_in,
  input  wire logic       termination_fault_in,
  input  wire logic       load_switch_fault_in,
  input  wire logic       third_ldo_fault_in,
  input  wire logic       termination_discharge_out,
  input  wire logic [1:0] aux_ldo_discharge_sel_out,
  input  wire logic       aux_ldo_keep_on_in_emergency_out,
  input  wire logic [3:0] aux_ldo_voltage_code_out,
  input  wire logic       aux_ldo_enable_out,
  input  wire logic       aux_ldo_run_out,
  input  wire logic       shutdown_req_out
);
  logic       rst_seen_q;
  logic       any_fault;
  logic       run_want;
  logic [8:0] cfg;
  assign any_fault = analog5v_fault_in | aux_ldo_fault_in |
    termination_fault_in | load_switch_fault_in | third_ldo_fault_in;
  assign run_want = aux_ldo_enable_out &
    (!shutdown_req_out | aux_ldo_keep_on_in_emergency_out);
  assign cfg = {termination_discharge_out, aux_ldo_discharge_sel_out,
    aux_ldo_keep_on_in_emergency_out, aux_ldo_voltage_code_out,
    aux_ldo_enable_out};
  // The cycle after reset still shows reset-time history, so skip it.
  always_ff @(posedge clk_in)
    rst_seen_q <= rst_in;
  default clocking cb @(posedge clk_in);
  endclocking
  ////////////////////////////////////////
  property p_reset_cfg;
    rst_in |=> aux_ldo_discharge_sel_out == 2'h1 &&
      aux_ldo_keep_on_in_emergency_out && !termination_discharge_out;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("config outputs wrong after reset");
  property p_reset_code;
    rst_in |=> aux_ldo_voltage_code_out == otp_aux_ldo_voltage_code_in &&
      aux_ldo_enable_out == otp_aux_ldo_enable_in;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("voltage code or enable not loaded from defaults");
  property p_reset_quiet;
    rst_in |=> sda_oe_n_out && !shutdown_req_out && !aux_ldo_run_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active during reset");
  property p_run_eq;
    disable iff (rst_in || rst_seen_q) aux_ldo_run_out == $past(run_want);
  endproperty
  a_run_eq: assert property (p_run_eq)
    else $error("aux regulator run level wrong");
  property p_run_off;
    disable iff (rst_in || rst_seen_q)
      $rose(shutdown_req_out) && !aux_ldo_keep_on_in_emergency_out
      |=> !aux_ldo_run_out [*2];
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("aux regulator kept on through shutdown");
  property p_sd_sticky;
    disable iff (rst_in) shutdown_req_out |=> shutdown_req_out;
  endproperty
  a_sd_sticky: assert property (p_sd_sticky)
    else $error("shutdown request dropped before reset");
  property p_sd_cause;
    disable iff (rst_in || rst_seen_q)
      $rose(shutdown_req_out) |-> $past(any_fault, 3);
  endproperty
  a_sd_cause: assert property (p_sd_cause)
    else $error("shutdown without a rail fault");
  property p_cfg_scl_low;
    disable iff (rst_in || rst_seen_q) $changed(cfg) |-> !scl_in;
  endproperty
  a_cfg_scl_low: assert property (p_cfg_scl_low)
    else $error("config changed outside a bus write");
  property p_ack_hold;
    disable iff (rst_in) $fell(sda_oe_n_out) |-> !sda_oe_n_out [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data line drive too short");
  c_sd_rise: cover property (disable iff (rst_in) $rose(shutdown_req_out));
  c_run_fall: cover property (disable iff (rst_in) $fell(aux_ldo_run_out));
  c_ack: cover property (disable iff (rst_in) $fell(sda_oe_n_out));
endmodule : rail_fault_regs_chk

bind pmic_rail_fault_ctrl_regs rail_fault_regs_chk i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_oe_n_out(sda_oe_n_out),
  .otp_aux_ldo_voltage_code_in(otp_aux_ldo_voltage_code_in),
  .otp_aux_ldo_enable_in(otp_aux_ldo_enable_in),
  .analog5v_fault_in(analog5v_fault_in),
  .aux_ldo_fault_in(aux_ldo_fault_in),
  .termination_fault_in(termination_fault_in),
  .load_switch_fault_in(load_switch_fault_in),
  .third_ldo_fault_in(third_ldo_fault_in),
  .termination_discharge_out(termination_discharge_out),
  .aux_ldo_discharge_sel_out(aux_ldo_discharge_sel_out),
  .aux_ldo_keep_on_in_emergency_out(aux_ldo_keep_on_in_emergency_out),
  .aux_ldo_voltage_code_out(aux_ldo_voltage_code_out),
  .aux_ldo_enable_out(aux_ldo_enable_out),
  .aux_ldo_run_out(aux_ldo_run_out),
  .shutdown_req_out(shutdown_req_out)
);
`default_nettype wire

/* bench/i2c_host_model.sv */
// Behavioural serial bus host driving clock and open-drain data.
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  input  wire logic clk_in,
  input  wire logic sda_line_in,
  output var  logic scl_out,
  output var  logic sda_rel_out
);
  initial
  begin
    scl_out = 1'h1;
    sda_rel_out = 1'h1;
  end
  // Six clocks a phase keeps both clock levels above five clocks.
  task automatic tick;
    repeat (6) @(negedge clk_in);
  endtask : tick
  task automatic put_bit(input logic b, output logic s);
    sda_rel_out = b;
    tick();
    scl_out = 1'h1;
    tick();
    s = sda_line_in;
    scl_out = 1'h0;
    tick();
  endtask : put_bit
  task automatic start;
    sda_rel_out = 1'h1;
    tick();
    scl_out = 1'h1;
    tick();
    sda_rel_out = 1'h0;
    tick();
    scl_out = 1'h0;
    tick();
  endtask : start
  task automatic stop;
    sda_rel_out = 1'h0;
    tick();
    scl_out = 1'h1;
    tick();
    sda_rel_out = 1'h1;
    tick();
  endtask : stop
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'h1, s);
    ack = !s;
  endtask : put_byte
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d,
                           output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({a, 1'h0}, k0);
    put_byte(p, k1);
    put_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
                          output logic [7:0] d, output logic ok);
    logic k0, k1, k2, s;
    start();
    put_byte({a, 1'h0}, k0);
    put_byte(p, k1);
    start();
    put_byte({a, 1'h1}, k2);
    for (int i = 7; i >= 0; i--)
      put_bit(1'h1, d[i]);
    put_bit(1'h1, s);
    stop();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

/* bench/pmic_rail_fault_ctrl_regs_bench.sv */
// Self-checking bench for the rail fault register bank.
`timescale 1ns/1ps
`default_nettype none
`include "rail_fault_params.svh"

module pmic_rail_fault_ctrl_regs_bench;
  localparam logic [6:0] DEV = `DEV_ADDR_DEFAULT;
  logic       clk_in, rst_in, scl, sda_rel, sda_oe_n, sda_line, ok, sda_o;
  logic       otp_en, term_dis, keep, en, run, sd;
  logic [1:0] disc_sel;
  logic [3:0] otp_code, code;
  logic [4:0] fault_v;
  logic [6:0] good_v;
  logic [31:0] seed, r;
  int         n_fail, compares;
  int         fbit[7] = '{4, 3, 2, 1, 0, 1, 1};
  logic [7:0] clr[7] = '{8'h20, 8'h10, 8'h08, 8'h06, 8'h01, 8'h04, 8'h02};
  assign sda_line = sda_rel & (sda_oe_n | sda_o);
  i2c_host_model i_host (.clk_in(clk_in), .sda_line_in(sda_line),
    .scl_out(scl), .sda_rel_out(sda_rel));
  pmic_rail_fault_ctrl_regs i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .otp_aux_ldo_voltage_code_in(otp_code), .otp_aux_ldo_enable_in(otp_en),
    .analog5v_fault_in(fault_v[4]), .aux_ldo_fault_in(fault_v[3]),
    .termination_fault_in(fault_v[2]), .load_switch_fault_in(fault_v[1]),
    .third_ldo_fault_in(fault_v[0]), .second_ldo_good_in(good_v[6]),
    .stepdown_rail_six_good_in(good_v[5]),
    .stepdown_rail_five_good_in(good_v[4]),
    .stepdown_rail_four_good_in(good_v[3]),
    .stepdown_rail_three_good_in(good_v[2]),
    .stepdown_rail_two_good_in(good_v[1]),
    .stepdown_rail_one_good_in(good_v[0]),
    .termination_discharge_out(term_dis), .aux_ldo_discharge_sel_out(disc_sel),
    .aux_ldo_keep_on_in_emergency_out(keep), .aux_ldo_voltage_code_out(code),
    .aux_ldo_enable_out(en), .aux_ldo_run_out(run), .shutdown_req_out(sd));
  ////////////////////////////////////////
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic cmp(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] p, d);
    i_host.write_reg(DEV, p, d, ok);
    cmp("write ack", 8'h01, {7'h00, ok});
  endtask : wr
  task automatic rd(input logic [7:0] p, exp);
    logic [7:0] d;
    i_host.read_reg(DEV, p, d, ok);
    cmp("read ack", 8'h01, {7'h00, ok});
    cmp("read data", exp, d);
  endtask : rd
  task automatic do_reset;
    rst_in = 1'h1;
    repeat (16) @(negedge clk_in);
    rst_in = 1'h0;
    repeat (4) @(negedge clk_in);
  endtask : do_reset
  function automatic logic [7:0] good_exp();
    return {good_v[6], 1'h0, good_v[5:0]};
  endfunction : good_exp
  initial
  begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    seed = 32'h1b3a_e059;
    r = $random(seed);
    {otp_en, otp_code} = r[4:0];
    fault_v = 5'h00;
    good_v = 7'h00;
    do_reset();
    rd(`REG_FAULT_MASK, 8'h37);
    rd(`REG_DISCHARGE, 8'h61);
    rd(`REG_AUX_LDO, {2'h1, 1'h1, otp_code, otp_en});
    rd(`REG_RAIL_GOOD, 8'h00);
    wr(`REG_FAULT_MASK, 8'hFF);
    rd(`REG_FAULT_MASK, 8'h7F);
    wr(8'hB5, 8'hFF);
    rd(8'hB5, 8'h00);
    i_host.write_reg(DEV ^ 7'h01, `REG_FAULT_MASK, 8'h00, ok);
    cmp("foreign ack", 8'h00, {7'h00, ok});
    rd(`REG_FAULT_MASK, 8'h7F);
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      good_v = r[30:24];
      wr(`REG_FAULT_MASK, r[7:0]);
      rd(`REG_FAULT_MASK, r[7:0] & 8'h7F);
      wr(`REG_DISCHARGE, r[15:8]);
      rd(`REG_DISCHARGE, r[15:8]);
      cmp("discharge pin", {7'h00, r[12]}, {7'h00, term_dis});
      wr(`REG_AUX_LDO, r[23:16]);
      rd(`REG_AUX_LDO, r[23:16]);
      cmp("aux pins", r[23:16], {disc_sel, keep, code, en});
      wr(`REG_RAIL_GOOD, r[7:0]);
      rd(`REG_RAIL_GOOD, good_exp());
    end
    // Shutdown is sticky, so each rail and code gets a fresh reset.
    for (int i = 0; i < 7; i++)
    begin
      do_reset();
      wr(`REG_AUX_LDO, {2'h1, i[0], 4'h9, 1'h1});
      wr(`REG_FAULT_MASK, 8'h3F);
      fault_v[fbit[i]] = 1'h1;
      repeat (8) @(negedge clk_in);
      cmp("masked shutdown", 8'h00, {7'h00, sd});
      cmp("aux run", 8'h01, {7'h00, run});
      wr(`REG_FAULT_MASK, 8'h3F & ~clr[i]);
      cmp("shutdown", 8'h01, {7'h00, sd});
      cmp("aux run", {7'h00, i[0]}, {7'h00, run});
      fault_v = 5'h00;
    end
    print_verdict();
  end
endmodule : pmic_rail_fault_ctrl_regs_bench
`default_nettype wire
